// ===== pkg/txpmk_regs.svh
/*
 * Named constants of the transmitter power-mode and keying control:
 * clock rate, settling times, divider and synthesizer ratios.
 * Assumes the core clock is the crystal oscillator clock at 200 MHz.
 */
`ifndef TXPMK_REGS_SVH
`define TXPMK_REGS_SVH

// core clock period in ns (200 MHz)
`define TXPMK_CLK_PERIOD_NS 5
// typical lock time of oscillator and synthesizer, in ms
`define TXPMK_LOCK_TIME_MS 1
// least wait before the controller may use the clock or the amplifier, in ms
`define TXPMK_GUARD_TIME_MS 4
// longest times round down to whole cycles
`define TXPMK_LOCK_CYCLES (`TXPMK_LOCK_TIME_MS * 1000000 / `TXPMK_CLK_PERIOD_NS)
`define TXPMK_GUARD_CYCLES (`TXPMK_GUARD_TIME_MS * 1000000 / `TXPMK_CLK_PERIOD_NS)
// width of the settling counter, holds the guard count
`define TXPMK_CNT_W 20
// clock output divides the crystal clock by this
`define TXPMK_CLK_DIV 4
`define TXPMK_DIV_W 2
// carrier to reference multiplication
`define TXPMK_VCO_RATIO 7'h40
`define TXPMK_RATIO_W 7
`define TXPMK_RATIO_OFF 7'h00
// shortest bit times at the highest keying rates, in core cycles
`define TXPMK_ASK_BIT_CYCLES (1000000000 / (`TXPMK_CLK_PERIOD_NS * 50000))
`define TXPMK_FSK_BIT_CYCLES (1000000000 / (`TXPMK_CLK_PERIOD_NS * 32000))

`endif

// ===== pkg/txpmk_pkg.sv
/*
 * Types of the transmitter power-mode and keying control.
 * Assumes txpmk_regs.svh is on the include path.
 */
`include "txpmk_regs.svh"

package txpmk_pkg;

    typedef enum logic [1:0] {
        TXPMK_STANDBY  = 2'b00,
        TXPMK_STARTUP  = 2'b01,
        TXPMK_READY    = 2'b10,
        TXPMK_TRANSMIT = 2'b11
    } txpmk_state_t;

    // level pins from the controller
    typedef struct packed {
        logic chip_enable;
        logic amplifier_on;
        logic pull_closed;
    } txpmk_pins_t;

    // power domains that are switched
    typedef struct packed {
        logic crystal_oscillator;
        logic synth;
        logic clk_drv;
        logic amp;
    } txpmk_pwr_t;

    typedef struct packed {
        logic [`TXPMK_DIV_W-1:0] cnt;
        logic clk_out;
    } txpmk_div_state_t;

    typedef struct packed {
        txpmk_state_t state;
        logic [`TXPMK_CNT_W-1:0] cnt;
        txpmk_pins_t sync1;
        txpmk_pins_t sync2;
        txpmk_pwr_t pwr;
        logic locked;
        logic guard_done;
        logic early_key;
        logic freq_low;
        logic [`TXPMK_RATIO_W-1:0] ratio;
    } txpmk_state_reg_t;

endpackage : txpmk_pkg

// ===== logic/txpmk_clkdiv.sv
/*
 * Divider for the clock output returned to the controller.
 * Assumes run_i comes from a flop on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "txpmk_regs.svh"

module txpmk_clkdiv (
    input wire logic core_clk_i, // crystal clock
    input wire logic reset_i,    // async reset, active high
    input wire logic run_i,      // oscillator running
    output logic clk_div_o       // crystal clock divided by four
);

    txpmk_pkg::txpmk_div_state_t r;
    txpmk_pkg::txpmk_div_state_t next_r;

    always_comb begin
        next_r = r;
        if (run_i) begin
            next_r.cnt = r.cnt + 1'b1;
            next_r.clk_out = r.cnt[`TXPMK_DIV_W-1];
        end else begin
            next_r.cnt = '0;
            next_r.clk_out = 1'b0;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign clk_div_o = r.clk_out;

endmodule // txpmk_clkdiv

`default_nettype wire

// ===== logic/txpmk_ctrl.sv
/*
 * Power-mode and keying control of a crystal-referenced transmitter.
 * Assumes the core clock is the crystal oscillator clock and that the
 * enable, amplifier and pulling-switch levels arrive asynchronously.
 */
`timescale 1ns/1ps
`default_nettype none
`include "txpmk_regs.svh"

// Notes on behaviour
// R1: clock output runs at a quarter of crystal frequency while oscillator runs.
// R2: synthesizer locks carrier to sixty-four times the crystal frequency.
// R3: both enables low puts everything off in standby.
// R4: chip enable high starts oscillator, synthesizer and clock driver.
// R5: chip enable alone runs oscillator, synthesizer and clock, no transmit.
// R6: both enables high run all blocks including the amplifier.
// R7: amplifier follows the amplifier enable level, giving amplitude keying.
// R8: oscillator and synthesizer lock within one millisecond of enable.
// R9: controller waits four milliseconds before using clock or amplifier.
// R10: amplitude keying holds amplifier low during wait, then toggles it.
// R11: ending transmission drops amplifier, restores controller clock, drops enable.
// R12: frequency keying sets amplifier high then toggles the pulling switch.
// R13: closed pulling switch gives a lower transmit frequency.
// R14: frequency keying end drops amplifier and clock before chip enable.
// R15: symbol rate stays within 50 kBaud amplitude, 32 kBaud frequency keying.
// R16: controller switches to the clock output only after the wait.
// R17: controller never enables amplifier early and aborts keying without enable.
module txpmk_ctrl #(
    parameter logic [`TXPMK_CNT_W-1:0] LOCK_CYCLES = `TXPMK_CNT_W'(`TXPMK_LOCK_CYCLES),
    parameter logic [`TXPMK_CNT_W-1:0] GUARD_CYCLES = `TXPMK_CNT_W'(`TXPMK_GUARD_CYCLES)
) (
    input wire logic core_clk_i,                   // crystal clock
    input wire logic reset_i,                      // async reset, active high
    input wire txpmk_pkg::txpmk_pins_t pins_i,     // enable, amplifier and switch levels
    output txpmk_pkg::txpmk_pwr_t pwr_o,           // power domain states
    output logic clk_out_o,                        // divided clock to the controller
    output logic locked_o,                         // synthesizer locked
    output logic guard_done_o,                     // settling wait elapsed
    output logic early_key_o,                      // amplifier raised before the wait ended
    output logic freq_low_o,                       // carrier pulled to the lower frequency
    output logic [`TXPMK_RATIO_W-1:0] ratio_o,     // carrier to reference ratio
    output txpmk_pkg::txpmk_state_t state_o        // power mode
);

    txpmk_pkg::txpmk_state_reg_t r;
    txpmk_pkg::txpmk_state_reg_t next_r;
    logic ce;
    logic amp;
    logic sw;

    assign ce = r.sync2.chip_enable;
    assign amp = r.sync2.amplifier_on;
    assign sw = r.sync2.pull_closed;

    always_comb begin
        next_r = r;
        next_r.sync1 = pins_i;
        next_r.sync2 = r.sync1;
        if (!ce) begin
            // R3 standby all off
            next_r.state = txpmk_pkg::TXPMK_STANDBY;
            next_r.cnt = '0;
            next_r.locked = 1'b0;
            next_r.guard_done = 1'b0;
            next_r.early_key = 1'b0;
        end else begin
            if (r.cnt != GUARD_CYCLES) begin
                next_r.cnt = r.cnt + 1'b1;
            end
            // R8 lock time
            if (r.cnt == LOCK_CYCLES - 1'b1) begin
                next_r.locked = 1'b1;
            end
            if (r.cnt == GUARD_CYCLES - 1'b1) begin
                next_r.guard_done = 1'b1;
            end
            // R17 amplifier raised early is flagged, standby clear wins
            if (amp && !r.guard_done) begin
                next_r.early_key = 1'b1;
            end
            case (r.state)
                txpmk_pkg::TXPMK_STANDBY: begin
                    next_r.state = txpmk_pkg::TXPMK_STARTUP;
                end
                txpmk_pkg::TXPMK_STARTUP: begin
                    if (amp) begin
                        next_r.state = txpmk_pkg::TXPMK_TRANSMIT;
                    end else if (r.locked) begin
                        next_r.state = txpmk_pkg::TXPMK_READY;
                    end
                end
                txpmk_pkg::TXPMK_READY: begin
                    if (amp) begin
                        next_r.state = txpmk_pkg::TXPMK_TRANSMIT;
                    end
                end
                txpmk_pkg::TXPMK_TRANSMIT: begin
                    if (!amp) begin
                        next_r.state = r.locked ? txpmk_pkg::TXPMK_READY : txpmk_pkg::TXPMK_STARTUP;
                    end
                end
                default: begin
                    next_r.state = txpmk_pkg::TXPMK_STANDBY;
                end
            endcase
        end
        // R4 R5 enable runs oscillator, synthesizer, clock driver
        next_r.pwr.crystal_oscillator = ce;
        next_r.pwr.synth = ce;
        next_r.pwr.clk_drv = ce;
        // R6 R7 amplifier follows its enable while chip enabled
        next_r.pwr.amp = ce && amp;
        // R2 fixed multiple of the reference
        next_r.ratio = ce ? `TXPMK_VCO_RATIO : `TXPMK_RATIO_OFF;
        // R13 closed switch lowers the reference
        next_r.freq_low = ce && sw;
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // R1 quarter rate clock
    txpmk_clkdiv txpmk_clkdiv_i (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .run_i(r.pwr.crystal_oscillator),
        .clk_div_o(clk_out_o)
    );

    assign pwr_o = r.pwr;
    assign locked_o = r.locked;
    assign guard_done_o = r.guard_done;
    assign early_key_o = r.early_key;
    assign freq_low_o = r.freq_low;
    assign ratio_o = r.ratio;
    assign state_o = r.state;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (reset_i);

    // R3 standby check
    standby_all_off_a: assert property ( // R3
        !ce |=> pwr_o == '0 && ratio_o == `TXPMK_RATIO_OFF && !freq_low_o
    ) else $error("standby left a function on");

    // R4 start on enable
    enable_start_a: assert property ( // R4
        $rose(ce) |=> pwr_o.crystal_oscillator && pwr_o.synth && pwr_o.clk_drv
    ) else $error("enable did not start oscillator and clock");

    // R5 oscillator only mode
    osc_only_a: assert property ( // R5
        ce && !amp |=> !pwr_o.amp && pwr_o.crystal_oscillator && state_o != txpmk_pkg::TXPMK_TRANSMIT
    ) else $error("transmit active without amplifier enable");

    // R6 transmit all on
    transmit_all_on_a: assert property ( // R6
        pwr_o.amp |-> pwr_o.crystal_oscillator && pwr_o.synth && pwr_o.clk_drv
    ) else $error("amplifier on without oscillator chain");

    // R7 amplifier keying
    pa_follows_a: assert property ( // R7
        ##1 pwr_o.amp == $past(ce && amp)
    ) else $error("amplifier does not follow its enable");

    // R1 divided clock
    clk_quarter_a: assert property ( // R1
        pwr_o.crystal_oscillator [*7] |-> clk_out_o == $past(clk_out_o, 4) && clk_out_o != $past(clk_out_o, 2)
    ) else $error("clock output not a quarter of crystal clock");

    // R8 lock time
    lock_time_a: assert property ( // R8
        $rose(locked_o) |-> $past(r.cnt) == LOCK_CYCLES - 1'b1
    ) else $error("lock reported at wrong time");

    // R9 settling wait
    guard_time_a: assert property ( // R9
        $rose(guard_done_o) |-> $past(r.cnt) == GUARD_CYCLES - 1'b1 && locked_o
    ) else $error("settling wait reported at wrong time");

    // R2 carrier ratio
    vco_ratio_a: assert property ( // R2
        pwr_o.synth |-> ratio_o == `TXPMK_VCO_RATIO
    ) else $error("synthesizer ratio wrong");

    // R13 pulled frequency
    pull_low_a: assert property ( // R13
        ce && sw |=> freq_low_o ##0 ratio_o == `TXPMK_VCO_RATIO
    ) else $error("closed switch did not lower frequency");

    // R17 early keying flag
    early_key_a: assert property ( // R17
        ce && amp && !guard_done_o |=> early_key_o
    ) else $error("early amplifier enable not flagged");

    // R8 ready after lock
    ready_needs_lock_a: assert property ( // R8
        state_o == txpmk_pkg::TXPMK_READY |-> locked_o
    ) else $error("ready state without lock");

    // R8 wait ends after lock
    guard_after_lock_a: assert property ( // R8
        guard_done_o |-> locked_o
    ) else $error("settling wait done before lock");

    // R1 clock idle when oscillator off
    clk_idle_low_a: assert property ( // R1
        !pwr_o.crystal_oscillator |=> !clk_out_o
    ) else $error("clock output running with oscillator off");

    // R3 standby clears status
    standby_clear_a: assert property ( // R3
        !ce |=> !locked_o && !guard_done_o && !early_key_o && state_o == txpmk_pkg::TXPMK_STANDBY
    ) else $error("standby kept lock or wait status");

    lock_reached_c: cover property ($rose(locked_o));
    transmit_c: cover property (guard_done_o && $rose(pwr_o.amp));
    pull_key_c: cover property (pwr_o.amp && $rose(freq_low_o));
    back_standby_c: cover property ($fell(pwr_o.crystal_oscillator));

endmodule // txpmk_ctrl

`default_nettype wire

// ===== tb/txpmk_mcu_model.sv
/*
 * Behavioural controller that sequences the enables and keys the carrier.
 * Assumes pin levels are sampled by the device on the rising clock edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "txpmk_regs.svh"

module txpmk_mcu_model #(
    parameter int GUARD_CYCLES = 80,
    parameter int ASK_BIT_CYCLES = `TXPMK_ASK_BIT_CYCLES,
    parameter int FSK_BIT_CYCLES = `TXPMK_FSK_BIT_CYCLES
) (
    input wire logic core_clk_i,              // crystal clock
    output var txpmk_pkg::txpmk_pins_t pins_o // enable, amplifier and switch levels
);
    initial pins_o = 3'h0;

    // pins change only at the falling edge
    task automatic drive(input logic ce, input logic amp, input logic pull);
        @(negedge core_clk_i);
        pins_o = {ce, amp, pull};
    endtask

    task automatic power_up();
        drive(1'b1, 1'b0, 1'b0);
        repeat (GUARD_CYCLES + 4) @(negedge core_clk_i);
    endtask

    task automatic key_ask(input logic bit_v);
        drive(1'b1, bit_v, 1'b0);
        repeat (ASK_BIT_CYCLES) @(negedge core_clk_i);
    endtask

    task automatic key_fsk(input logic bit_v);
        drive(1'b1, 1'b1, bit_v);
        repeat (FSK_BIT_CYCLES) @(negedge core_clk_i);
    endtask

    task automatic shut_down();
        drive(1'b1, 1'b0, 1'b0);
        repeat (8) @(negedge core_clk_i);
        drive(1'b0, 1'b0, 1'b0);
    endtask
endmodule // txpmk_mcu_model

`default_nettype wire

// ===== tb/tx_power_mode_and_keying_control_bench.sv
/*
 * Self-checking bench of the power-mode and keying control.
 * Assumes the controller model drives every pin at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check(8'(a), 8'(b))

module tx_power_mode_and_keying_control_bench;
    localparam int LOCK = 20;
    localparam int GUARD = 80;
    logic core_clk_i = 1'b0;
    logic reset_i = 1'b1;
    txpmk_pkg::txpmk_pins_t pins;
    txpmk_pkg::txpmk_pwr_t pwr;
    txpmk_pkg::txpmk_state_t state;
    logic clk_out, locked, guard_done, early_key, freq_low;
    logic [6:0] ratio;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    always #2.5 core_clk_i = ~core_clk_i;

    txpmk_mcu_model #(.GUARD_CYCLES(GUARD)) txpmk_mcu_model_i (
        .core_clk_i(core_clk_i), .pins_o(pins));

    txpmk_ctrl #(.LOCK_CYCLES(20'(LOCK)), .GUARD_CYCLES(20'(GUARD))) txpmk_ctrl_i (
        .core_clk_i(core_clk_i), .reset_i(reset_i), .pins_i(pins), .pwr_o(pwr),
        .clk_out_o(clk_out), .locked_o(locked), .guard_done_o(guard_done),
        .early_key_o(early_key), .freq_low_o(freq_low), .ratio_o(ratio), .state_o(state));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic settle();
        repeat (6) @(negedge core_clk_i);
    endtask

    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic t_standby();
        `CHK(pwr, 4'h0);
        `CHK(ratio, 7'h00);
        `CHK({clk_out, state}, 3'h0);
    endtask

    task automatic t_power_up();
        int n, lock_at, guard_at, rises, highs;
        logic last;
        n = 0;
        lock_at = 0;
        guard_at = 0;
        fork
            txpmk_mcu_model_i.power_up();
            while (n < GUARD + 12) begin
                @(negedge core_clk_i);
                n++;
                if (locked === 1'b1 && lock_at == 0) lock_at = n;
                if (guard_done === 1'b1 && guard_done == 1'b1 && guard_at == 0) guard_at = n;
                if (n == 6) begin
                    `CHK(pwr, 4'he);
                    `CHK(ratio, 7'h40);
                    `CHK(state, txpmk_pkg::TXPMK_STARTUP);
                end
            end
        join
        `CHK(lock_at >= LOCK + 2 && lock_at <= LOCK + 6, 1'b1);
        `CHK(guard_at >= GUARD + 2 && guard_at <= GUARD + 6, 1'b1);
        `CHK({state, pwr}, {2'h0, txpmk_pkg::TXPMK_READY, 4'he});
        rises = 0;
        highs = 0;
        last = clk_out;
        repeat (40) begin
            @(negedge core_clk_i);
            if (clk_out === 1'b1 && last === 1'b0) rises++;
            if (clk_out === 1'b1) highs++;
            last = clk_out;
        end
        `CHK(rises, 8'h0a);
        `CHK(highs, 8'h14);
    endtask

    task automatic t_ask();
        logic [4:0] bits;
        bits = 5'h0d;
        for (int i = 0; i < 5; i++) begin
            txpmk_mcu_model_i.key_ask(bits[i]);
            `CHK(pwr, {3'h7, bits[i]});
            `CHK(state, bits[i] ? txpmk_pkg::TXPMK_TRANSMIT : txpmk_pkg::TXPMK_READY);
        end
        `CHK(early_key, 1'b0);
    endtask

    task automatic t_fsk();
        for (int i = 0; i < 4; i++) begin
            txpmk_mcu_model_i.key_fsk(i[0]);
            `CHK(freq_low, i[0]);
            `CHK(pwr, 4'hf);
        end
        txpmk_mcu_model_i.shut_down();
        settle();
        `CHK(pwr, 4'h0);
        `CHK({ratio, locked}, 8'h00);
        `CHK({guard_done, freq_low, state}, 4'h0);
    endtask

    task automatic t_refuse();
        txpmk_mcu_model_i.drive(1'b0, 1'b1, 1'b1);
        settle();
        `CHK(pwr, 4'h0);
        `CHK(freq_low, 1'b0);
        txpmk_mcu_model_i.drive(1'b1, 1'b1, 1'b0);
        settle();
        `CHK(early_key, 1'b1);
        `CHK(pwr, 4'hf);
        txpmk_mcu_model_i.drive(1'b0, 1'b0, 1'b0);
        settle();
        `CHK({early_key, pwr}, 5'h00);
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(negedge core_clk_i);
        reset_i = 1'b0;
        settle();
        t_standby();
        t_power_up();
        t_ask();
        t_fsk();
        t_refuse();
        wrap_up();
    end
endmodule // tx_power_mode_and_keying_control_bench

`default_nettype wire
